/* File: rtl/usft_defines.svh */
`ifndef USFT_DEFINES_SVH
`define USFT_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define USFT_ADDR_CTRL    8'h00
`define USFT_ADDR_FORMAT  8'h04
`define USFT_ADDR_BAUD    8'h08
`define USFT_ADDR_DATA    8'h0c
`define USFT_ADDR_STATUS  8'h10

// ****************************************************************
// Control fields
// ****************************************************************
`define USFT_CTRL_TXEN    0
`define USFT_CTRL_DBL     1
`define USFT_CTRL_SYNC    2
`define USFT_CTRL_POL     3
`define USFT_CTRL_MASTER  4
`define USFT_CTRL_BIT9    5
`define USFT_CTRL_RXEN    6
`define USFT_CTRL_W       7

// ****************************************************************
// Format fields
// ****************************************************************
`define USFT_FMT_SIZE_LO  0
`define USFT_FMT_PAR_LO   3
`define USFT_FMT_STOP     5
`define USFT_FMT_W        6
`define USFT_FMT_RESET    6'h03

// ****************************************************************
// Status fields
// ****************************************************************
`define USFT_STAT_DRE     0
`define USFT_STAT_TXC     1
`define USFT_STAT_RXC     2
`define USFT_STAT_FE      3

// ****************************************************************
// Timing counts
// ****************************************************************
`define USFT_OVS_NORMAL   4'hf
`define USFT_OVS_DOUBLE   4'h7
`define USFT_SIZE_NINE    3'h7

`endif

/* File: rtl/usft_pkg.sv */
package usft_pkg;

    typedef enum logic [5:0] {
        TX_IDLE  = 6'h01,
        TX_START = 6'h02,
        TX_DATA  = 6'h04,
        TX_PAR   = 6'h08,
        TX_STOP1 = 6'h10,
        TX_STOP2 = 6'h20
    } usft_tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } usft_rx_state_t;

endpackage

/* File: rtl/usft_baud_if.sv */
`timescale 1ns/100ps
interface usft_baud_if #(parameter int DIV_W = 12);
    logic [DIV_W-1:0] divisor;
    logic             reload;
    logic             tick;
    modport gen  (input divisor, input reload, output tick);
    modport user (output divisor, output reload, input tick);
endinterface

/* File: rtl/usft_baud.sv */
`timescale 1ns/100ps
module usft_baud
    import usft_pkg::*;
#(
    parameter int DIV_W = 12
)(
    input  wire logic   pclk,
    input  wire logic   presetn,
    usft_baud_if.gen    bif
);

    logic [DIV_W-1:0] cnt_r;
    logic             tick_r;

    // ****************************************************************
    // Down-counter, reload at zero or on divisor write
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else if (bif.reload)
        begin
            cnt_r  <= bif.divisor;
            tick_r <= 1'b0;
        end
        else if (cnt_r == '0)
        begin
            cnt_r  <= bif.divisor;
            tick_r <= 1'b1;
        end
        else
        begin
            cnt_r  <= cnt_r - 1'b1;
            tick_r <= 1'b0;
        end
    end

    assign bif.tick = tick_r;

    a_tick_period : assert property (@(posedge pclk) disable iff (!presetn)
        tick_r && !bif.reload && bif.divisor == '0 && !$past(bif.reload)
        |=> tick_r || bif.reload)
        else $error("Baud tick missing with zero divisor");

endmodule

/* File: rtl/usft_top.sv */
`timescale 1ns/100ps
`include "usft_defines.svh"

// How it works
// - Sync mode: clock pin input slave, output master
// - Sample on edge opposite to output change
// - Polarity picks change and sample edges
// - Thirty frame formats supported
// - Start, data LSB first, parity, stops
// - Next frame follows directly or line idles high
// - One format setting shared by both directions
// - Size, parity and stop fields select format
// - Only first stop bit checked for error
// - Parity is data xor, odd inverts
// - Enabled transmitter owns serial output pin
// - Sync transmitter uses transfer clock pin
// - Data write fills buffer, moves when idle or at frame end
// - Frame sent at baud or transfer clock rate
// - Unused high data bits ignored
// - Size code 7 means nine bits
// - Parity only when upper mode bit set
// - Baud counter reloads at zero or write
// - Empty flag tracks transmit buffer
module usft_top
    import usft_pkg::*;
#(
    parameter int DIV_W  = 12,
    parameter int ADDR_W = 8
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    input  wire logic              rxd,
    output logic                   txd,
    output logic                   txd_oe,
    input  wire logic              transfer_clock_pin_i,
    output logic                   transfer_clock_pin_o,
    output logic                   transfer_clock_pin_oe
);

    if (DIV_W < 1 || DIV_W > 16) begin : g_chk_div
        $error("DIV_W out of range");
    end
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk_addr
        $error("ADDR_W out of range");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [3:0] data_bits(input logic [2:0] size);
        data_bits = (size == `USFT_SIZE_NINE) ? 4'h9
                  : {1'b0, size} + 4'h5;
    endfunction

    function automatic logic [8:0] data_mask(input logic [2:0] size);
        data_mask = 9'h1ff >> (4'h9 - data_bits(size));
    endfunction

    logic                       pready_r, pslverr_r;
    logic [31:0]                prdata_r;
    logic [`USFT_CTRL_W-1:0]    ctrl_r;
    logic [`USFT_FMT_W-1:0]     fmt_r;
    logic [DIV_W-1:0]           baud_r;
    logic [8:0]                 txbuf_r;
    logic                       txbuf_full_r, txc_r;
    logic [8:0]                 rxdata_r;
    logic                       rxc_r, fe_r;
    logic                       wr_en, rd_en;
    logic                       rxd_s1, rxd_s2, xck_s1, xck_s2, xck_s3;
    logic                       xck_r, txd_r, txd_oe_r, xck_oe_r;
    logic                       rise, fall, chg_edge, smp_edge;
    logic [3:0]                 tx_div_r, rx_cnt_r, ovs;
    logic                       tx_step, rx_tick;
    usft_tx_state_t             tx_st_r;
    usft_rx_state_t             rx_st_r;
    logic [8:0]                 tx_sh_r, rx_sh_r;
    logic [3:0]                 tx_idx_r, rx_idx_r;
    logic                       tx_par_r, tx_load, tx_done, rx_done, rx_fe;

    wire        sync_mode_select = ctrl_r[`USFT_CTRL_SYNC];
    wire        clock_polarity   = ctrl_r[`USFT_CTRL_POL];
    wire        transmit_enable  = ctrl_r[`USFT_CTRL_TXEN];
    wire        double_speed     = ctrl_r[`USFT_CTRL_DBL];
    wire        master           = ctrl_r[`USFT_CTRL_MASTER];
    wire [2:0]  character_size   = fmt_r[`USFT_FMT_SIZE_LO +: 3];
    wire [1:0]  parity_mode      = fmt_r[`USFT_FMT_PAR_LO +: 2];
    wire        stop_bit_select  = fmt_r[`USFT_FMT_STOP];
    wire [3:0]  nbits            = data_bits(character_size);

    usft_baud_if #(.DIV_W(DIV_W)) bif ();

    usft_baud #(.DIV_W(DIV_W)) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .bif     (bif)
    );

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign wr_en = psel && penable && pready_r && pwrite;
    assign rd_en = psel && penable && pready_r && !pwrite;
    assign bif.divisor = baud_r;
    assign bif.reload  = wr_en && paddr == `USFT_ADDR_BAUD;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end
        else
        begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            if (psel && penable && !pready_r)
            begin
                case (paddr)
                    `USFT_ADDR_CTRL:   prdata_r <= 32'(ctrl_r);
                    `USFT_ADDR_FORMAT: prdata_r <= 32'(fmt_r);
                    `USFT_ADDR_BAUD:   prdata_r <= 32'(baud_r);
                    `USFT_ADDR_DATA:   prdata_r <= 32'(rxdata_r);
                    `USFT_ADDR_STATUS: prdata_r <= {28'h0, fe_r, rxc_r, txc_r, !txbuf_full_r};
                    default:           pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= '0;
            fmt_r  <= `USFT_FMT_RESET;
            baud_r <= '0;
        end
        else if (wr_en)
        begin
            if (paddr == `USFT_ADDR_CTRL)
                ctrl_r <= pwdata[`USFT_CTRL_W-1:0];
            if (paddr == `USFT_ADDR_FORMAT)
                fmt_r <= pwdata[`USFT_FMT_W-1:0];
            if (paddr == `USFT_ADDR_BAUD)
                baud_r <= pwdata[DIV_W-1:0];
        end
    end

    // Transmit buffer and empty flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txbuf_r      <= 9'h0;
            txbuf_full_r <= 1'b0;
        end
        else if (wr_en && paddr == `USFT_ADDR_DATA)
        begin
            txbuf_r      <= {ctrl_r[`USFT_CTRL_BIT9], pwdata[7:0]};
            txbuf_full_r <= 1'b1;
        end
        else if (tx_load)
            txbuf_full_r <= 1'b0;
    end

    // Status flags, hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txc_r    <= 1'b0;
            rxc_r    <= 1'b0;
            fe_r     <= 1'b0;
            rxdata_r <= 9'h0;
        end
        else
        begin
            if (tx_done && !txbuf_full_r)
                txc_r <= 1'b1;
            else if (wr_en && paddr == `USFT_ADDR_STATUS && pwdata[`USFT_STAT_TXC])
                txc_r <= 1'b0;
            if (rx_done)
            begin
                rxc_r    <= 1'b1;
                fe_r     <= rx_fe;
                rxdata_r <= rx_sh_r & data_mask(character_size);
            end
            else if (rd_en && paddr == `USFT_ADDR_DATA)
                rxc_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Pin synchronisers and clock edges
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            xck_s1 <= 1'b0;
            xck_s2 <= 1'b0;
            xck_s3 <= 1'b0;
        end
        else
        begin
            rxd_s1 <= rxd;
            rxd_s2 <= rxd_s1;
            xck_s1 <= transfer_clock_pin_i;
            xck_s2 <= xck_s1;
            xck_s3 <= xck_s2;
        end
    end

    // Master clock: baud tick toggles the pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xck_r    <= 1'b0;
            xck_oe_r <= 1'b0;
        end
        else
        begin
            xck_oe_r <= sync_mode_select && master;
            if (sync_mode_select && master && bif.tick)
                xck_r <= !xck_r;
            else if (!(sync_mode_select && master))
                xck_r <= clock_polarity;
        end
    end

    assign rise = master ? (bif.tick && !xck_r) : (xck_s2 && !xck_s3);
    assign fall = master ? (bif.tick && xck_r) : (!xck_s2 && xck_s3);
    assign chg_edge = clock_polarity ? fall : rise;
    assign smp_edge = clock_polarity ? rise : fall;
    assign ovs = double_speed ? `USFT_OVS_DOUBLE : `USFT_OVS_NORMAL;
    assign tx_step = sync_mode_select ? chg_edge
                   : (bif.tick && tx_div_r == ovs);
    assign rx_tick = sync_mode_select ? smp_edge : (bif.tick && rx_cnt_r == 4'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_div_r <= 4'h0;
        else if (bif.tick)
            tx_div_r <= (tx_div_r >= ovs) ? 4'h0 : tx_div_r + 4'h1;
    end

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    assign tx_load = txbuf_full_r && transmit_enable && tx_step
                  && (tx_st_r == TX_IDLE || tx_done);
    assign tx_done = tx_step && ((tx_st_r == TX_STOP1 && !stop_bit_select)
                  || tx_st_r == TX_STOP2);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_st_r  <= TX_IDLE;
            tx_sh_r  <= 9'h0;
            tx_idx_r <= 4'h0;
            tx_par_r <= 1'b0;
            txd_r    <= 1'b1;
        end
        else if (tx_load)
        begin
            tx_st_r  <= TX_START;
            tx_sh_r  <= txbuf_r & data_mask(character_size);
            tx_par_r <= ^(txbuf_r & data_mask(character_size)) ^ parity_mode[0];
            tx_idx_r <= 4'h0;
            txd_r    <= 1'b0;
        end
        else if (tx_step)
        begin
            case (tx_st_r)
                TX_START, TX_DATA:
                begin
                    txd_r    <= tx_sh_r[0];
                    tx_sh_r  <= tx_sh_r >> 1;
                    tx_idx_r <= tx_idx_r + 4'h1;
                    tx_st_r  <= TX_DATA;
                    if (tx_st_r == TX_DATA && tx_idx_r == nbits)
                    begin
                        txd_r   <= parity_mode[1] ? tx_par_r : 1'b1;
                        tx_st_r <= parity_mode[1] ? TX_PAR : TX_STOP1;
                    end
                end
                TX_PAR:
                begin
                    txd_r   <= 1'b1;
                    tx_st_r <= TX_STOP1;
                end
                TX_STOP1:
                begin
                    txd_r   <= 1'b1;
                    tx_st_r <= stop_bit_select ? TX_STOP2 : TX_IDLE;
                end
                TX_STOP2:
                begin
                    txd_r   <= 1'b1;
                    tx_st_r <= TX_IDLE;
                end
                TX_IDLE:
                    txd_r <= 1'b1;
                default:
                    tx_st_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            txd_oe_r <= 1'b0;
        else
            txd_oe_r <= transmit_enable || tx_st_r != TX_IDLE || txbuf_full_r;
    end

    // ****************************************************************
    // Receiver frame check
    // ****************************************************************
    assign rx_done = rx_tick && rx_st_r == RX_STOP;
    assign rx_fe   = !rxd_s2;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_r  <= RX_IDLE;
            rx_cnt_r <= 4'h0;
            rx_sh_r  <= 9'h0;
            rx_idx_r <= 4'h0;
        end
        else if (!ctrl_r[`USFT_CTRL_RXEN])
            rx_st_r <= RX_IDLE;
        else
        begin
            if (bif.tick && !sync_mode_select)
                rx_cnt_r <= (rx_cnt_r == 4'h0) ? ovs : rx_cnt_r - 4'h1;
            case (rx_st_r)
                RX_IDLE:
                    if (!rxd_s2 && (!sync_mode_select || smp_edge))
                    begin
                        rx_st_r  <= sync_mode_select ? RX_DATA : RX_START;
                        rx_cnt_r <= ovs >> 1;
                        rx_idx_r <= 4'h0;
                    end
                RX_START:
                    if (rx_tick)
                        rx_st_r <= rxd_s2 ? RX_IDLE : RX_DATA;
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_sh_r  <= {rxd_s2, rx_sh_r[8:1]};
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_idx_r == nbits - 4'h1)
                        begin
                            rx_sh_r <= {rxd_s2, rx_sh_r[8:1]} >> (4'h9 - nbits);
                            rx_st_r <= parity_mode[1] ? RX_PAR : RX_STOP;
                        end
                    end
                RX_PAR:
                    if (rx_tick)
                        rx_st_r <= RX_STOP;
                RX_STOP:
                    if (rx_tick)
                        rx_st_r <= RX_IDLE;
                default:
                    rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pready                = pready_r;
    assign prdata                = prdata_r;
    assign pslverr               = pslverr_r;
    assign txd                   = txd_r;
    assign txd_oe                = txd_oe_r;
    assign transfer_clock_pin_o  = xck_r;
    assign transfer_clock_pin_oe = xck_oe_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_start_low : assert property (@(posedge pclk) disable iff (!presetn)
        tx_load |=> !txd_r && tx_st_r == TX_START)
        else $error("Start bit not driven low");
    a_stop_high : assert property (@(posedge pclk) disable iff (!presetn)
        tx_st_r == TX_STOP1 || tx_st_r == TX_STOP2 |-> txd_r)
        else $error("Stop bit not high");
    a_idle_high : assert property (@(posedge pclk) disable iff (!presetn)
        tx_st_r == TX_IDLE && $past(tx_st_r) == TX_IDLE |-> txd_r)
        else $error("Idle line not high");
    a_dre_clear : assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `USFT_ADDR_DATA |=> txbuf_full_r)
        else $error("Empty flag not cleared on write");
    a_pin_owned : assert property (@(posedge pclk) disable iff (!presetn)
        $past(transmit_enable) |-> txd_oe_r)
        else $error("Serial output not driven");
    a_master_clk : assert property (@(posedge pclk) disable iff (!presetn)
        $past(sync_mode_select && master) |-> xck_oe_r)
        else $error("Master clock pin not driven");
    a_par_order : assert property (@(posedge pclk) disable iff (!presetn)
        tx_st_r == TX_PAR |-> parity_mode[1] && txd_r == tx_par_r)
        else $error("Parity bit wrong");
    a_sync_step : assert property (@(posedge pclk) disable iff (!presetn)
        sync_mode_select && tx_step |-> !smp_edge)
        else $error("Change and sample on same edge");
    a_txc_set : assert property (@(posedge pclk) disable iff (!presetn)
        tx_done && !txbuf_full_r |=> txc_r)
        else $error("Complete flag not set");

    c_frame : cover property (@(posedge pclk) tx_done);
    c_back2back : cover property (@(posedge pclk) tx_done && tx_load);
    c_rx_frame : cover property (@(posedge pclk) rx_done && !rx_fe);
    c_fe : cover property (@(posedge pclk) rx_done && rx_fe);

endmodule

/* File: test/usft_remote.sv */
`timescale 1ns/100ps
// ****
// Remote receiver
// ****
module usft_remote (
    input  wire logic       pclk,
    input  wire logic       txd,
    input  wire logic       transfer_clock_pin,
    input  wire logic       sync,
    input  wire logic       brk,
    input  wire logic [3:0] nbits,
    input  wire logic [7:0] bit_cyc,
    output logic            rxd,
    output logic [12:0]     word,
    output int              frames
);
    task automatic step(input int c);
        if (sync)
            @(negedge transfer_clock_pin);
        else
            repeat (c) @(posedge pclk);
    endtask
    // Loopback into the receiver, forced low while brk is high
    assign rxd = txd & ~brk;
    initial
    begin
        frames = 0;
        word = '0;
        forever
        begin
            @(negedge txd);
            step(bit_cyc / 2);
            for (int i = 0; i < nbits; i++)
            begin
                word[i] = txd;
                if (i < nbits - 1)
                    step(bit_cyc);
            end
            frames++;
        end
    end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
`include "usft_defines.svh"
module testbench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        rxd;
    logic        txd;
    logic        txd_oe;
    logic        xck_o;
    logic        xck_oe;
    logic        sync;
    logic [3:0]  nb;
    logic [7:0]  bc;
    logic [12:0] word;
    logic [31:0] rd;
    logic        err;
    logic        pol;
    logic        brk;
    logic        ext_clk;
    logic [1:0]  ext_div;
    int          frames;
    int          mismatches;
    int          check_count;
    wire         transfer_clock_pin = xck_oe ? xck_o : ext_clk;

    usft_top usft_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .rxd, .txd, .txd_oe, .transfer_clock_pin_i(transfer_clock_pin),
        .transfer_clock_pin_o(xck_o), .transfer_clock_pin_oe(xck_oe));
    usft_remote usft_remote_i (.pclk, .txd, .transfer_clock_pin(transfer_clock_pin ^ pol), .sync, .brk, .nbits(nb),
        .bit_cyc(bc), .rxd, .word, .frames);

    // ****
    // Tasks
    // ****
    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int b);
        do
            apb(1'b0, `USFT_ADDR_STATUS, 32'h0);
        while (rd[b] !== 1'b1);
    endtask
    task automatic send(input logic [7:0] c, input logic [5:0] f, input logic [8:0] d,
                        input logic [7:0] b, input int cnt);
        int          n;
        int          f0;
        logic [12:0] e;
        n = (f[2:0] == 3'h7) ? 9 : 5 + f[2:0];
        e = '1;
        e[0] = 1'b0;
        for (int i = 0; i < n; i++)
            e[i + 1] = d[i];
        if (f[4])
            e[n + 1] = ^(d & 9'((1 << n) - 1)) ^ f[3];
        sync = c[2];
        pol = c[3];
        bc = b;
        nb = 4'(n + 2 + f[4] + f[5]);
        f0 = frames;
        apb(1'b1, `USFT_ADDR_FORMAT, {26'h0, f});
        apb(1'b1, `USFT_ADDR_CTRL, {24'h0, c});
        apb(1'b1, `USFT_ADDR_STATUS, 32'h2);
        for (int k = 0; k < cnt; k++)
        begin
            poll(0);
            apb(1'b1, `USFT_ADDR_DATA, {24'h0, d[7:0]});
        end
        if (cnt > 1)
        begin
            apb(1'b0, `USFT_ADDR_STATUS, 32'h0);
            chk("empty", 32'(rd[0]), 32'h0);
        end
        wait (frames == f0 + cnt);
        chk("frame", 32'(word & ((13'h1 << nb) - 1)), 32'(e & ((13'h1 << nb) - 1)));
        chk("txd_oe", 32'(txd_oe), 32'h1);
        chk("clk_oe", 32'(xck_oe), 32'(c[2] & c[4]));
        poll(1);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever
            #5 pclk = ~pclk;
    end
    // Slave transfer clock, 80 ns period
    always @(posedge pclk)
    begin
        ext_div <= ext_div + 2'h1;
        if (ext_div == 2'h3)
            ext_clk <= ~ext_clk;
    end
    initial
    begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sync = 1'b0;
        pol = 1'b0;
        brk = 1'b0;
        ext_clk = 1'b0;
        ext_div = 2'h0;
        nb = 4'ha;
        bc = 8'h20;
        mismatches = 0;
        check_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `USFT_ADDR_FORMAT, 32'h0);
        chk("format", rd, 32'h3);
        apb(1'b0, `USFT_ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        apb(1'b1, `USFT_ADDR_BAUD, 32'h1);
        send(8'h41, 6'h03, 9'h0a5, 8'h20, 2);
        apb(1'b0, `USFT_ADDR_DATA, 32'h0);
        chk("rx_data", rd, 32'h0a5);
        apb(1'b0, `USFT_ADDR_STATUS, 32'h0);
        chk("rx_flags", 32'(rd[3:2]), 32'h0);
        send(8'h01, 6'h10, 9'h0ea, 8'h20, 1);
        send(8'h01, 6'h39, 9'h03b, 8'h20, 1);
        send(8'h21, 6'h2f, 9'h155, 8'h20, 1);
        send(8'h03, 6'h12, 9'h055, 8'h10, 1);
        send(8'h15, 6'h03, 9'h03c, 8'h04, 1);
        send(8'h0d, 6'h03, 9'h0c3, 8'h08, 1);
        apb(1'b1, `USFT_ADDR_CTRL, 32'h40);
        brk <= 1'b1;
        poll(2);
        chk("frame_err", 32'(rd[3]), 32'h1);
        brk <= 1'b0;
        print_verdict();
    end
endmodule
